// File: ced_exception_detect.sv
// exception detection between decode/execute and exception sequencer
`timescale 1ns/10ps
`default_nettype none
module ced_exception_detect (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// instruction from decode, valid for one cycle per instruction
	input  wire logic        inst_valid_i,
	input  wire logic [15:0] opcode_i,
	input  wire logic [31:0] inst_pc_i,
	input  wire logic [31:0] next_pc_i,
	input  wire logic [15:0] halt_operand_i,
	input  wire logic        divisor_zero_i,
	// next instruction opcode, seen ahead of execution
	input  wire logic        lookahead_valid_i,
	input  wire logic [15:0] lookahead_opcode_i,
	// processor status word before this instruction
	input  wire logic [15:0] status_word_i,
	// instruction completion from execute
	input  wire logic        inst_done_i,
	// sequencer hand-off
	output logic             exc_valid_o,
	output logic [2:0]       exc_kind_o,
	output logic [7:0]       exc_vector_o,
	output logic [11:0]      exc_offset_o,
	output logic [31:0]      exc_pc_o,
	output logic [15:0]      exc_status_o,
	output logic             inhibit_o
);
	// decoder results for current instruction
	logic legal;
	logic line_a;
	logic line_f;
	logic super_only;
	logic divide;
	logic is_halt;
	// decoder results for look-ahead opcode
	logic la_halt;

	// current instruction classifier
	ced_opdec u_dec (
		.opcode_i     (opcode_i),
		.legal_o      (legal),
		.line_a_o     (line_a),
		.line_f_o     (line_f),
		.super_only_o (super_only),
		.divide_o     (divide),
		.halt_o       (is_halt)
	);

	// look-ahead classifier, only halt detection used
	ced_opdec u_la (
		.opcode_i     (lookahead_opcode_i),
		.legal_o      (),
		.line_a_o     (),
		.line_f_o     (),
		.super_only_o (),
		.divide_o     (),
		.halt_o       (la_halt)
	);

	// registered outputs
	logic                 next_exc_valid;
	ced_pkg::ced_kind_type next_kind;
	ced_pkg::ced_kind_type kind;
	logic [7:0]           next_vector;
	logic [11:0]          next_offset;
	logic [31:0]          next_pc;
	logic [15:0]          next_status;
	logic                 next_inhibit;
	// pending trace across the halt
	ced_pkg::ced_halt_type halt_st;
	ced_pkg::ced_halt_type next_halt_st;
	// held instruction info until completion
	logic                 pend;
	logic                 next_pend;
	logic [31:0]          pend_pc;
	logic [31:0]          next_pend_pc;
	logic [15:0]          pend_sw;
	logic [15:0]          next_pend_sw;
	logic                 pend_trace;
	logic                 next_pend_trace;
	logic                 pend_before_halt;
	logic                 next_pend_before_halt;

	// working terms
	logic user_mode;
	logic traced;
	logic fault_illegal;
	logic fault_priv;
	logic fault_div;
	logic [15:0] halt_sw;

	// next-state logic for reporting and trace tracking
	always_comb begin
		user_mode     = !status_word_i[ced_pkg::SUPER_BIT_POS];
		traced        = status_word_i[ced_pkg::TRACE_BIT_POS];
		// only the opcode word is judged, never extension words
		fault_illegal = !legal;
		fault_priv    = super_only && user_mode;
		fault_div     = divide && divisor_zero_i;
		halt_sw       = halt_operand_i;
		next_exc_valid = 1'b0;
		next_kind      = kind;
		next_vector    = exc_vector_o;
		next_offset    = exc_offset_o;
		next_pc        = exc_pc_o;
		next_status    = exc_status_o;
		next_inhibit   = 1'b0;
		next_halt_st   = halt_st;
		next_pend      = pend;
		next_pend_pc   = pend_pc;
		next_pend_sw   = pend_sw;
		next_pend_trace = pend_trace;
		next_pend_before_halt = pend_before_halt;
		if (inst_valid_i) begin
			// faults: fixed priority, exactly one reported
			if (line_a) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_LINE_A;
				next_vector    = ced_pkg::VEC_LINE_A;
			end else if (line_f) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_LINE_F;
				next_vector    = ced_pkg::VEC_LINE_F;
			end else if (fault_illegal) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_ILLEGAL;
				next_vector    = ced_pkg::VEC_ILLEGAL;
			end else if (fault_priv) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_PRIV;
				next_vector    = ced_pkg::VEC_PRIV;
			end else if (fault_div) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_DIVZERO;
				next_vector    = ced_pkg::VEC_DIVZERO;
			end
			if (next_exc_valid) begin
				// fault: instruction suppressed, trace dropped
				next_inhibit   = 1'b1;
				next_offset    = {2'h0, next_vector, 2'h0};
				next_pc        = inst_pc_i;
				// stacked status carries trace at bit 15
				next_status    = status_word_i;
				next_pend      = 1'b0;
				next_halt_st   = ced_pkg::HST_IDLE;
			end else if (is_halt) begin
				// halt loads status; trace if old or new value traces
				next_pend       = 1'b1;
				next_pend_pc    = next_pc_i;
				next_pend_sw    = halt_sw;
				// traced already, or the new value turns tracing on
				next_pend_trace = traced ||
					halt_sw[ced_pkg::TRACE_BIT_POS];
				next_pend_before_halt = 1'b0;
				next_halt_st    = ced_pkg::HST_POST;
			end else begin
				// ordinary instruction, trace on completion
				next_pend       = 1'b1;
				next_pend_sw    = status_word_i;
				next_pend_trace = traced;
				// halt next: trace stacks the halt address
				next_pend_before_halt = traced && lookahead_valid_i &&
					la_halt;
				next_pend_pc    = next_pc_i;
				next_halt_st    = next_pend_before_halt ?
					ced_pkg::HST_PRE : ced_pkg::HST_IDLE;
			end
		end else if (pend && inst_done_i) begin
			next_pend = 1'b0;
			if (pend_trace) begin
				next_exc_valid = 1'b1;
				next_kind      = ced_pkg::EXC_TRACE;
				next_vector    = ced_pkg::VEC_TRACE;
				next_offset    = {2'h0, ced_pkg::VEC_TRACE, 2'h0};
				// pc of halt (pre) or after it (post / normal)
				next_pc        = pend_pc;
				next_status    = pend_sw;
			end
			next_halt_st = ced_pkg::HST_IDLE;
		end
		// divide-by-zero offset fixed by the table
		if (next_kind == ced_pkg::EXC_DIVZERO)
			next_offset = ced_pkg::OFS_DIVZERO;
	end

	// state and output registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exc_valid_o      <= 1'b0;
			kind             <= ced_pkg::EXC_NONE;
			exc_vector_o     <= 8'h00;
			exc_offset_o     <= 12'h000;
			exc_pc_o         <= 32'h0000_0000;
			exc_status_o     <= 16'h0000;
			inhibit_o        <= 1'b0;
			halt_st          <= ced_pkg::HST_IDLE;
			pend             <= 1'b0;
			pend_pc          <= 32'h0000_0000;
			pend_sw          <= 16'h0000;
			pend_trace       <= 1'b0;
			pend_before_halt <= 1'b0;
		end else begin
			exc_valid_o      <= next_exc_valid;
			kind             <= next_kind;
			exc_vector_o     <= next_vector;
			exc_offset_o     <= next_offset;
			exc_pc_o         <= next_pc;
			exc_status_o     <= next_status;
			inhibit_o        <= next_inhibit;
			halt_st          <= next_halt_st;
			pend             <= next_pend;
			pend_pc          <= next_pend_pc;
			pend_sw          <= next_pend_sw;
			pend_trace       <= next_pend_trace;
			pend_before_halt <= next_pend_before_halt;
		end
	end

	// kind output straight from its register
	assign exc_kind_o = kind;
endmodule : ced_exception_detect
`default_nettype wire

// File: ced_exception_detect_assertions.sv
// concurrent checks on the exception detection ports
`timescale 1ns/10ps
`default_nettype none
module ced_exception_detect_assertions (
	// clock, reset and request side
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic        inst_valid_i,
	input wire logic [15:0] opcode_i,
	input wire logic [31:0] inst_pc_i,
	input wire logic [15:0] halt_operand_i,
	input wire logic        divisor_zero_i,
	input wire logic [15:0] status_word_i,
	input wire logic        inst_done_i,
	// sequencer side
	input wire logic        exc_valid_o,
	input wire logic [2:0]  exc_kind_o,
	input wire logic [7:0]  exc_vector_o,
	input wire logic [11:0] exc_offset_o,
	input wire logic [31:0] exc_pc_o,
	input wire logic [15:0] exc_status_o,
	input wire logic        inhibit_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// legal divide presented while tracing
	sequence traced_div_s;
		inst_valid_i && status_word_i[15] && opcode_i == 16'h80c1
			&& !divisor_zero_i;
	endsequence
	// its completion
	sequence done_s;
		inst_done_i && !inst_valid_i;
	endsequence
	line_a_a: assert property (inst_valid_i && opcode_i == 16'ha000 |=>
		exc_valid_o && exc_kind_o == 3'h2 && exc_vector_o == 8'h0a && inhibit_o)
		else $error("line a report wrong");
	line_f_a: assert property (inst_valid_i && opcode_i == 16'hf000 |=>
		exc_vector_o == 8'h0b && exc_pc_o == $past(inst_pc_i))
		else $error("line f report wrong");
	illegal_op_a: assert property (inst_valid_i && opcode_i == 16'h4afc |=>
		exc_valid_o && exc_kind_o == 3'h1 && exc_vector_o == 8'h04)
		else $error("illegal opcode not reported");
	div_zero_a: assert property (inst_valid_i && opcode_i == 16'h80c1
		&& divisor_zero_i && status_word_i[13] |=> exc_kind_o == 3'h5
		&& exc_vector_o == 8'h05 && exc_offset_o == 12'h014)
		else $error("divide by zero report wrong");
	user_priv_a: assert property (inst_valid_i && opcode_i == 16'h4e7b
		&& !status_word_i[13] |=> exc_valid_o && exc_kind_o == 3'h4 && inhibit_o)
		else $error("privilege violation missed");
	trace_done_a: assert property (traced_div_s ##1 done_s |=> exc_valid_o
		&& exc_kind_o == 3'h6 && exc_vector_o == 8'h09 && !inhibit_o)
		else $error("trace not reported");
	stack_bit_a: assert property (inst_valid_i && status_word_i[15]
		##1 exc_valid_o |-> exc_status_o[15])
		else $error("stacked trace bit lost");
	halt_trace_a: assert property (inst_valid_i && opcode_i == 16'h4e72
		&& status_word_i[15] && status_word_i[13] ##1 done_s |=> exc_valid_o
		&& exc_kind_o == 3'h6 && exc_status_o == $past(halt_operand_i, 2))
		else $error("traced halt not traced");
	vec_offset_a: assert property (exc_valid_o |->
		exc_offset_o == {2'b00, exc_vector_o, 2'b00})
		else $error("offset not vector times four");
	one_report_a: assert property (traced_div_s ##1 done_s |->
		!exc_valid_o ##1 exc_valid_o ##1 !exc_valid_o)
		else $error("report count wrong");
endmodule : ced_exception_detect_assertions
bind ced_exception_detect ced_exception_detect_assertions u_chk (.mclk_i,
	.resetn_i, .inst_valid_i, .opcode_i, .inst_pc_i, .halt_operand_i,
	.divisor_zero_i,
	.status_word_i, .inst_done_i, .exc_valid_o, .exc_kind_o, .exc_vector_o,
	.exc_offset_o, .exc_pc_o, .exc_status_o, .inhibit_o);
`default_nettype wire

// File: ced_exception_detect_tb.sv
// self-checking bench for the exception detection block
`timescale 1ns/10ps
`default_nettype none
module ced_exception_detect_tb;
	// one expected report
	typedef struct packed {
		logic [2:0]  kind;
		logic [7:0]  vec;
		logic [31:0] pc;
		logic [15:0] st;
		logic [15:0] msk;
	} ced_exp_type;
	logic        mclk_i, resetn_i, inst_valid_i, divisor_zero_i;
	logic        lookahead_valid_i, inst_done_i, exc_valid_o, inhibit_o;
	logic [15:0] opcode_i, halt_operand_i, lookahead_opcode_i;
	logic [15:0] status_word_i, exc_status_o;
	logic [31:0] inst_pc_i, next_pc_i, exc_pc_o;
	logic [2:0]  exc_kind_o;
	logic [7:0]  exc_vector_o;
	logic [11:0] exc_offset_o;
	ced_exp_type exp_q[$];      // notes from the driver
	ced_exp_type e;             // note under comparison
	int          failures, comparisons;
	ced_exception_detect uut (.mclk_i, .resetn_i, .inst_valid_i, .opcode_i,
		.inst_pc_i, .next_pc_i, .halt_operand_i, .divisor_zero_i,
		.lookahead_valid_i, .lookahead_opcode_i, .status_word_i, .inst_done_i,
		.exc_valid_o, .exc_kind_o, .exc_vector_o, .exc_offset_o, .exc_pc_o,
		.exc_status_o, .inhibit_o);
	// 125 MHz core clock
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	// verdict, also for leftover notes
	task give_verdict;
		if (exp_q.size() != 0) failures++;
		if (failures == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	// one comparison
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		comparisons++;
		if (x !== s) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// one instruction, optional completion, note of the expected report
	task go(input logic [15:0] op, st, input logic dz, lav, dn,
		input logic [15:0] opd, input logic [2:0] k, input logic [7:0] v,
		input logic [15:0] es, em);
		logic [31:0] pc;
		pc = $urandom & 32'hfffffffe;
		@(posedge mclk_i);
		inst_valid_i <= 1'b1;
		opcode_i <= op;
		status_word_i <= st;
		divisor_zero_i <= dz;
		lookahead_valid_i <= lav;
		halt_operand_i <= opd;
		inst_pc_i <= pc;
		next_pc_i <= pc + 32'h2;
		// faults stack the whole incoming status word
		if (k != 3'h0)
			exp_q.push_back({k, v, (k == 3'h6) ? pc + 32'h2 : pc,
				(k == 3'h6) ? es : st, (k == 3'h6) ? em : 16'hffff});
		@(posedge mclk_i);
		inst_valid_i <= 1'b0;
		inst_done_i <= dn;
		@(posedge mclk_i);
		inst_done_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : go
	// watcher: each report takes the oldest note
	always @(posedge mclk_i) begin
		if (exc_valid_o === 1'b1) begin
			if (exp_q.size() == 0) chk("spare report", 32'h0, 32'h1);
			else begin
				e = exp_q.pop_front();
				chk("kind", 32'(e.kind), 32'(exc_kind_o));
				chk("vector", 32'(e.vec), 32'(exc_vector_o));
				chk("offset", 32'({e.vec, 2'b00}), 32'(exc_offset_o));
				chk("pc", e.pc, exc_pc_o);
				chk("status", 32'(e.st), 32'(exc_status_o & e.msk));
				chk("inhibit", 32'(e.kind != 3'h6), 32'(inhibit_o));
			end
		end
	end
	// watchdog: 16 instructions of 6 cycles each, wide margin
	initial begin
		repeat (5000) @(posedge mclk_i);
		failures++;
		give_verdict;
	end
	// main sequence
	initial begin
		{resetn_i, inst_valid_i, divisor_zero_i, lookahead_valid_i} = 4'h0;
		{inst_done_i, opcode_i, halt_operand_i, status_word_i} = 49'h0;
		{inst_pc_i, next_pc_i} = 64'h0;
		lookahead_opcode_i = ced_pkg::HALT_OPCODE;
		failures = 0;
		comparisons = 0;
		void'($urandom(90));
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		go(16'h0000, 16'h2000, 0, 0, 0, 0, 3'h1, 8'h04, 0, 0);
		go(16'h4afc, 16'h2000, 0, 0, 0, 0, 3'h1, 8'h04, 0, 0);
		go(16'ha000, 16'h2000, 0, 0, 0, 0, 3'h2, 8'h0a, 0, 0);
		go(16'hf000, 16'h2000, 0, 0, 0, 0, 3'h3, 8'h0b, 0, 0);
		go(16'ha000, 16'h8000, 1, 0, 1, 0, 3'h2, 8'h0a, 0, 0);
		go(16'h80c1, 16'h2000, 1, 0, 1, 0, 3'h5, 8'h05, 0, 0);
		go(16'h80c1, 16'h2000, 0, 0, 1, 0, 3'h0, 8'h00, 0, 0);
		go(ced_pkg::HALT_OPCODE, 0, 0, 0, 0, 0, 3'h4, 8'h08, 0, 0);
		go(ced_pkg::RTE_OPCODE, 0, 0, 0, 0, 0, 3'h4, 8'h08, 0, 0);
		go(ced_pkg::CRM_OPCODE, 0, 0, 0, 0, 0, 3'h4, 8'h08, 0, 0);
		go(16'h80c1, 16'ha000, 0, 0, 1, 0, 3'h6, 8'h09, 16'h8000, 16'h8000);
		go(16'h80c1, 16'ha000, 0, 1, 1, 0, 3'h6, 8'h09, 16'h8000, 16'h8000);
		go(ced_pkg::HALT_OPCODE, 16'ha000, 0, 0, 1, 16'ha700, 3'h6, 8'h09,
			16'ha700, 16'hffff);
		go(ced_pkg::HALT_OPCODE, 16'ha000, 0, 0, 1, 16'h2700, 3'h6, 8'h09,
			16'h2700, 16'hffff);
		go(ced_pkg::HALT_OPCODE, 16'h2000, 0, 0, 1, 16'ha000, 3'h6, 8'h09,
			16'ha000, 16'hffff);
		go(ced_pkg::HALT_OPCODE, 16'h2000, 0, 0, 1, 16'($urandom) & 16'h7fff,
			3'h0, 8'h00, 0, 0);
		give_verdict;
	end
endmodule : ced_exception_detect_tb
`default_nettype wire

// File: ced_opdec.sv
// opcode classifier: legality, line groups, privilege, divide class
`timescale 1ns/10ps
`default_nettype none
module ced_opdec (
	// opcode word
	input  wire logic [15:0] opcode_i,
	// classification
	output logic             legal_o,
	output logic             line_a_o,
	output logic             line_f_o,
	output logic             super_only_o,
	output logic             divide_o,
	output logic             halt_o
);
	// combinational decode of the whole 16-bit word
	always_comb begin
		line_a_o     = (opcode_i[15:12] == ced_pkg::LINE_A_GROUP);
		line_f_o     = (opcode_i[15:12] == ced_pkg::LINE_F_GROUP);
		halt_o       = (opcode_i == ced_pkg::HALT_OPCODE);
		// halt, return from exception, control register move
		super_only_o = halt_o ||
			(opcode_i == ced_pkg::RTE_OPCODE) ||
			(opcode_i == ced_pkg::CRM_OPCODE);
		// word divides plus long divide/remainder group
		divide_o     = ((opcode_i[15:12] == ced_pkg::DIVW_GROUP) &&
			(opcode_i[7:6] == ced_pkg::DIVW_SIZE)) ||
			(opcode_i[15:6] == ced_pkg::DIVL_OPHI);
		// unsupported words: both line groups, the 4afc word and the all-zero word
		legal_o      = !line_a_o && !line_f_o &&
			(opcode_i != 16'h4afc) && (opcode_i != 16'h0000);
	end
endmodule : ced_opdec
`default_nettype wire

// File: ced_pkg.sv
// constants and types for the exception detection block
package ced_pkg;
	// vector numbers
	localparam logic [7:0] VEC_ILLEGAL   = 8'h04;
	localparam logic [7:0] VEC_DIVZERO   = 8'h05;
	localparam logic [7:0] VEC_PRIV      = 8'h08;
	localparam logic [7:0] VEC_TRACE     = 8'h09;
	localparam logic [7:0] VEC_LINE_A    = 8'h0a;
	localparam logic [7:0] VEC_LINE_F    = 8'h0b;
	// vector table byte offset of the divide-by-zero entry
	localparam logic [11:0] OFS_DIVZERO  = 12'h014;
	// status word field positions
	localparam int TRACE_BIT_POS         = 15;
	localparam int SUPER_BIT_POS         = 13;
	// opcode group field
	localparam logic [3:0] LINE_A_GROUP  = 4'ha;
	localparam logic [3:0] LINE_F_GROUP  = 4'hf;
	// halt opcode with immediate status operand
	localparam logic [15:0] HALT_OPCODE  = 16'h4e72;
	// control register move opcode (supervisor only)
	localparam logic [15:0] CRM_OPCODE   = 16'h4e7b;
	// return from exception opcode (supervisor only)
	localparam logic [15:0] RTE_OPCODE   = 16'h4e73;
	// divide/remainder long group
	localparam logic [9:0] DIVL_OPHI     = 10'h131;
	// word divide groups: 1000 rrr x11 ...
	localparam logic [3:0] DIVW_GROUP    = 4'h8;
	localparam logic [1:0] DIVW_SIZE     = 2'h3;
	// exception kinds reported to the sequencer
	typedef enum logic [2:0] {
		EXC_NONE    = 3'b000,
		EXC_ILLEGAL = 3'b001,
		EXC_LINE_A  = 3'b010,
		EXC_LINE_F  = 3'b011,
		EXC_PRIV    = 3'b100,
		EXC_DIVZERO = 3'b101,
		EXC_TRACE   = 3'b110
	} ced_kind_type;
	// halt trace tracking state
	typedef enum logic [1:0] {
		HST_IDLE    = 2'b00,
		HST_PRE     = 2'b01,
		HST_POST    = 2'b10
	} ced_halt_type;
endpackage : ced_pkg
